// >>> core/ext_bus_cfg.svh
`ifndef EXT_BUS_CFG_SVH
`define EXT_BUS_CFG_SVH

// --------------------------------------------------------------
// address map of the multiplexed bus
// --------------------------------------------------------------
`define ADDR_W 24
`define MUX_LO_LSB 4
`define MUX_HI_LSB 12
`define DIRECT_LO_LSB 1
`define DIRECT_HI_LSB 20
`define PORT_ALL_ONES 8'hFF
`define CFG_QUASI 2'h0
`define CFG_HIZ 2'h1
`define INT_CODE_SIZE 24'h00_8000
`define RST_OUT_CYCLES 4'h8

`endif

// >>> core/ext_bus_pkg.sv
package ext_bus_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_ADDR = 6'b00_0010,
        ST_HOLD = 6'b00_0100,
        ST_STRB = 6'b00_1000,
        ST_WAIT = 6'b01_0000,
        ST_DONE = 6'b10_0000
    } bus_state_t;

    typedef enum logic [1:0] {
        KIND_FETCH = 2'h0,
        KIND_READ = 2'h1,
        KIND_WRITE = 2'h2
    } bus_kind_t;

endpackage : ext_bus_pkg

// >>> core/ext_bus_pins.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_cfg.svh"
// What this block does
// - drive address latch strobe high so the address part is captured.
// - pulse address latch strobe only during a bus cycle needing it.
// - program fetch strobe low only during external code fetches.
// - latch code source at reset release; 0 all external, 1 internal first.
// - after reset release the code source pin acts as wait input.
// - buffered clock output of core clock, software can disable it.
// - port 0 carries low data byte and address bits 4 to 11.
// - 16-bit bus: port 2 carries high data byte and address 12 to 19.
// - 8-bit bus: address lines on port 2 selectable in 4-bit groups.
// - shared pin is address bit 0 on 8-bit bus, high write strobe on 16.
// - address bits 1-3 and 20-23 on dedicated port pins.
// - 24 address lines reach 16 megabytes.
// - latch bus width select at reset end as default bus width.
// - dedicated low byte write strobe.
// - dedicated data read strobe apart from program fetch strobe.
// - during reset port 0 and 2 latches ones and pins quasi-bidirectional.
// - each pin output configuration set independently.
// - low reset pin resets ports and restarts at reset vector.
// - reset output low for external, watchdog or instruction reset.
module ext_bus_pins
    import ext_bus_pkg::*;
#(
    parameter int ADDR_W = `ADDR_W
) (
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic LINK_CLK_I,
    input wire logic RESET_PIN_N_I,
    input wire logic WDT_RESET_I,
    input wire logic CMD_RESET_I,
    input wire logic CODE_SOURCE_SELECT_I,
    input wire logic BUS_WIDTH_SELECT_I,
    input wire logic BUFFERED_CLOCK_OUTPUT_DISABLE_I,
    input wire logic [1:0] P2_ADDR_GROUPS_I,
    input wire logic REQ_VALID_I,
    input wire logic [1:0] REQ_KIND_I,
    input wire logic [ADDR_W-1:0] REQ_ADDR_I,
    input wire logic [15:0] REQ_WDATA_I,
    input wire logic REQ_HIGH_BYTE_I,
    input wire logic [15:0] PORT_CFG_I,
    output logic REQ_READY_O,
    output logic RSP_VALID_O,
    output logic [15:0] RSP_RDATA_O,
    output logic CODE_EXTERNAL_O,
    output logic BUS_WIDE_O,
    output logic CORE_RESET_O,
    output logic ADDR_LATCH_O,
    output logic PROGRAM_FETCH_STROBE_N_O,
    output logic DATA_READ_STROBE_N_O,
    output logic LOW_BYTE_WRITE_STROBE_N_O,
    output logic BUFFERED_CLOCK_OUTPUT_O,
    output logic RESET_INDICATOR_OUTPUT_N_O,
    input wire logic [7:0] P0_I,
    output logic [7:0] P0_O,
    output logic [7:0] P0_OE_O,
    input wire logic [7:0] P2_I,
    output logic [7:0] P2_O,
    output logic [7:0] P2_OE_O,
    output logic [3:0] P1_ADDR_O,
    output logic [1:0] P4_ADDR_O,
    output logic [1:0] P6_ADDR_O,
    output logic [15:0] PORT_CFG_O
);

    // --------------------------------------------------------------
    // link domain: bus wait pin sampled on external clock
    // --------------------------------------------------------------
    logic wait_l1_q, wait_l1_d;
    logic wait_l2_q, wait_l2_d;
    always_comb begin
        wait_l1_d = CODE_SOURCE_SELECT_I;
        wait_l2_d = wait_l1_q;
    end
    always_ff @(posedge LINK_CLK_I) begin
        wait_l1_q <= wait_l1_d;
        wait_l2_q <= wait_l2_d;
    end

    // --------------------------------------------------------------
    // pin synchronisers into core clock
    // --------------------------------------------------------------
    logic [4:0] s1_q, s1_d, s2_q, s2_d;
    logic rst_pin_n, ea_pin, bus_width_select_pin, wait_pin;
    always_comb begin
        s1_d = {wait_l2_q, BUS_WIDTH_SELECT_I, CODE_SOURCE_SELECT_I, RESET_PIN_N_I, 1'b0};
        s2_d = s1_q;
    end
    always_ff @(posedge CORE_CLK_I) begin
        s1_q <= s1_d;
        s2_q <= s2_d;
    end
    assign rst_pin_n = s2_q[1];
    assign ea_pin = s2_q[2];
    assign bus_width_select_pin = s2_q[3];
    assign wait_pin = s2_q[4];

    // --------------------------------------------------------------
    // reset tracking and strap capture
    // --------------------------------------------------------------
    logic in_reset_q, in_reset_d;
    logic code_ext_q, code_ext_d;
    logic wide_q, wide_d;
    logic [3:0] rst_cnt_q, rst_cnt_d;
    logic any_reset;
    assign any_reset = RESET_I | ~rst_pin_n | WDT_RESET_I | CMD_RESET_I;
    always_comb begin
        in_reset_d = any_reset;
        code_ext_d = code_ext_q;
        wide_d = wide_q;
        rst_cnt_d = rst_cnt_q;
        if (in_reset_q && !any_reset) begin
            code_ext_d = ~ea_pin;
            wide_d = bus_width_select_pin;
        end
        // stretch keeps short internal resets visible off chip
        if (any_reset) begin
            rst_cnt_d = `RST_OUT_CYCLES;
        end else if (rst_cnt_q != 4'h0) begin
            rst_cnt_d = rst_cnt_q - 4'h1;
        end
    end
    always_ff @(posedge CORE_CLK_I) begin
        if (RESET_I) begin
            in_reset_q <= 1'b1;
            code_ext_q <= 1'b1;
            wide_q <= 1'b0;
            rst_cnt_q <= `RST_OUT_CYCLES;
        end else begin
            in_reset_q <= in_reset_d;
            code_ext_q <= code_ext_d;
            wide_q <= wide_d;
            rst_cnt_q <= rst_cnt_d;
        end
    end
    assign CODE_EXTERNAL_O = code_ext_q;
    assign BUS_WIDE_O = wide_q;
    assign CORE_RESET_O = in_reset_q;
    assign RESET_INDICATOR_OUTPUT_N_O = ~(in_reset_q | (rst_cnt_q != 4'h0));

    // --------------------------------------------------------------
    // bus cycle sequencer
    // --------------------------------------------------------------
    bus_state_t st_q, st_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [1:0] kind_q, kind_d;
    logic hib_q, hib_d, rsp_q, rsp_d;
    logic ale_q, ale_d, program_fetch_strobe_q, program_fetch_strobe_d, rd_q, rd_d, wrl_q, wrl_d, wrh_q, wrh_d;
    logic drive_q, drive_d, data_phase_q, data_phase_d;

    always_comb begin
        st_d = st_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        kind_d = kind_q;
        hib_d = hib_q;
        rsp_d = 1'b0;
        ale_d = 1'b0;
        drive_d = drive_q;
        data_phase_d = data_phase_q;
        case (st_q)
            ST_IDLE: begin
                drive_d = 1'b0;
                data_phase_d = 1'b0;
                if (REQ_VALID_I && !in_reset_q) begin
                    addr_d = REQ_ADDR_I;
                    wdata_d = REQ_WDATA_I;
                    kind_d = REQ_KIND_I;
                    hib_d = REQ_HIGH_BYTE_I;
                    ale_d = 1'b1;
                    drive_d = 1'b1;
                    st_d = ST_ADDR;
                end
            end
            ST_ADDR: begin
                st_d = ST_HOLD;
            end
            ST_HOLD: begin
                data_phase_d = 1'b1;
                drive_d = (kind_q == KIND_WRITE);
                st_d = ST_STRB;
            end
            ST_STRB, ST_WAIT: begin
                if (wait_pin) begin
                    st_d = ST_WAIT;
                end else begin
                    rdata_d = {P2_I, P0_I};
                    st_d = ST_DONE;
                end
            end
            ST_DONE: begin
                rsp_d = 1'b1;
                drive_d = 1'b0;
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // --------------------------------------------------------------
    // strobes follow the next state
    // --------------------------------------------------------------
    // a strobe is already low in the cycle whose closing edge samples
    // the read data, so the memory has a whole cycle to answer
    logic strobe_window;
    always_comb begin
        strobe_window = (st_d == ST_STRB) || (st_d == ST_WAIT);
        program_fetch_strobe_d = ~(strobe_window && kind_d == KIND_FETCH);
        rd_d = ~(strobe_window && kind_d == KIND_READ);
        wrl_d = ~(strobe_window && kind_d == KIND_WRITE);
        wrh_d = ~(strobe_window && kind_d == KIND_WRITE && wide_q && hib_d);
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (in_reset_q || RESET_I) begin
            st_q <= ST_IDLE;
            addr_q <= '0;
            wdata_q <= 16'h0000;
            rdata_q <= 16'h0000;
            kind_q <= KIND_FETCH;
            hib_q <= 1'b0;
            rsp_q <= 1'b0;
            ale_q <= 1'b0;
            program_fetch_strobe_q <= 1'b1;
            rd_q <= 1'b1;
            wrl_q <= 1'b1;
            wrh_q <= 1'b1;
            drive_q <= 1'b0;
            data_phase_q <= 1'b0;
        end else begin
            st_q <= st_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            kind_q <= kind_d;
            hib_q <= hib_d;
            rsp_q <= rsp_d;
            ale_q <= ale_d;
            program_fetch_strobe_q <= program_fetch_strobe_d;
            rd_q <= rd_d;
            wrl_q <= wrl_d;
            wrh_q <= wrh_d;
            drive_q <= drive_d;
            data_phase_q <= data_phase_d;
        end
    end

    assign REQ_READY_O = (st_q == ST_IDLE) && !in_reset_q;
    assign RSP_VALID_O = rsp_q;
    assign RSP_RDATA_O = rdata_q;
    assign ADDR_LATCH_O = ale_q;
    assign PROGRAM_FETCH_STROBE_N_O = program_fetch_strobe_q;
    assign DATA_READ_STROBE_N_O = rd_q;
    assign LOW_BYTE_WRITE_STROBE_N_O = wrl_q;

    // --------------------------------------------------------------
    // pin muxing; idle ports hold their reset latch value of ones
    // --------------------------------------------------------------
    logic [7:0] p2_addr_mask;
    always_comb begin
        p2_addr_mask = 8'h00;
        for (int g = 0; g < 2; g++) begin
            if (32'(P2_ADDR_GROUPS_I) > g) begin
                p2_addr_mask[g*4 +: 4] = 4'hF;
            end
        end
    end

    always_comb begin
        P0_O = `PORT_ALL_ONES;
        P2_O = `PORT_ALL_ONES;
        P0_OE_O = 8'h00;
        P2_OE_O = 8'h00;
        if (st_q != ST_IDLE) begin
            P0_OE_O = {8{drive_q}};
            P0_O = data_phase_q ? wdata_q[7:0] : addr_q[`MUX_LO_LSB +: 8];
            if (wide_q) begin
                P2_OE_O = {8{drive_q}};
                P2_O = data_phase_q ? wdata_q[15:8] : addr_q[`MUX_HI_LSB +: 8];
            end else begin
                P2_OE_O = p2_addr_mask;
                P2_O = addr_q[`MUX_HI_LSB +: 8];
            end
        end
    end

    assign P1_ADDR_O = {addr_q[`DIRECT_LO_LSB +: 3], wide_q ? wrh_q : addr_q[0]};
    assign P4_ADDR_O = addr_q[`DIRECT_HI_LSB +: 2];
    assign P6_ADDR_O = addr_q[`DIRECT_HI_LSB + 2 +: 2];

    // --------------------------------------------------------------
    // per-pin configuration, quasi mode forced while in reset
    // --------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_cfg
            assign PORT_CFG_O[gi*2 +: 2] = in_reset_q ? `CFG_QUASI : PORT_CFG_I[gi*2 +: 2];
        end
    endgenerate

    // gated core clock; gating on a low level avoids runt pulses
    logic clk_en_q, clk_en_d;
    always_comb begin
        clk_en_d = ~BUFFERED_CLOCK_OUTPUT_DISABLE_I;
    end
    always_ff @(negedge CORE_CLK_I) begin
        clk_en_q <= clk_en_d;
    end
    assign BUFFERED_CLOCK_OUTPUT_O = CORE_CLK_I & clk_en_q;

endmodule : ext_bus_pins
`default_nettype wire

// >>> verification/ext_bus_pins_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ext_bus_pins_sva
    import ext_bus_pkg::*;
#(
    parameter int ADDR_W = 24
) (
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic REQ_VALID_I,
    input wire logic [1:0] REQ_KIND_I,
    input wire logic [ADDR_W-1:0] REQ_ADDR_I,
    input wire logic BUFFERED_CLOCK_OUTPUT_DISABLE_I,
    input wire logic REQ_READY_O,
    input wire logic RSP_VALID_O,
    input wire logic CORE_RESET_O,
    input wire logic ADDR_LATCH_O,
    input wire logic PROGRAM_FETCH_STROBE_N_O,
    input wire logic DATA_READ_STROBE_N_O,
    input wire logic LOW_BYTE_WRITE_STROBE_N_O,
    input wire logic BUFFERED_CLOCK_OUTPUT_O,
    input wire logic RESET_INDICATOR_OUTPUT_N_O,
    input wire logic [7:0] P0_O,
    input wire logic [7:0] P0_OE_O,
    input wire logic [15:0] PORT_CFG_O
);
// ----------------------------------------
// request capture
// ----------------------------------------
logic take;
logic [1:0] kind_q, kind_d;
logic [ADDR_W-1:0] addr_q, addr_d;
assign take = REQ_VALID_I && REQ_READY_O;
always_comb begin
    kind_d = take ? REQ_KIND_I : kind_q;
    addr_d = take ? REQ_ADDR_I : addr_q;
end
always_ff @(posedge CORE_CLK_I) begin
    kind_q <= kind_d;
    addr_q <= addr_d;
end
default clocking @(posedge CORE_CLK_I); endclocking
default disable iff (RESET_I);
a_ale_cause: assert property (take |=> ADDR_LATCH_O)
    else $error("latch strobe missing after take");
a_ale_pulse: assert property (ADDR_LATCH_O |=> !ADDR_LATCH_O [*4])
    else $error("latch strobe too long");
a_ale_addr: assert property (ADDR_LATCH_O |-> P0_OE_O == 8'hFF && P0_O == addr_q[11:4])
    else $error("port 0 address wrong");
a_fetch_only: assert property (!PROGRAM_FETCH_STROBE_N_O |-> kind_q == KIND_FETCH)
    else $error("fetch strobe outside fetch");
a_read_only: assert property (!DATA_READ_STROBE_N_O |-> kind_q == KIND_READ)
    else $error("read strobe outside read");
a_write_only: assert property (!LOW_BYTE_WRITE_STROBE_N_O |-> kind_q == KIND_WRITE)
    else $error("write strobe outside write");
a_rsp_bound: assert property (take |-> ##[5:300] RSP_VALID_O)
    else $error("no response");
a_reset_out: assert property (CORE_RESET_O |-> !RESET_INDICATOR_OUTPUT_N_O)
    else $error("reset output high in reset");
a_port_dflt: assert property (CORE_RESET_O |-> PORT_CFG_O == 16'h0000 && P0_OE_O == 8'h00 && P0_O == 8'hFF)
    else $error("port defaults wrong");
// negedge sampling sees the high phase, where the gate shows
a_clk_gate: assert property (@(negedge CORE_CLK_I) disable iff (RESET_I)
    $stable(BUFFERED_CLOCK_OUTPUT_DISABLE_I) |-> BUFFERED_CLOCK_OUTPUT_O == !BUFFERED_CLOCK_OUTPUT_DISABLE_I)
    else $error("clock output gate wrong");
c_write: cover property (take && REQ_KIND_I == KIND_WRITE);
c_read: cover property (take && REQ_KIND_I == KIND_READ);
c_fetch: cover property (take && REQ_KIND_I == KIND_FETCH);
endmodule : ext_bus_pins_sva
bind ext_bus_pins ext_bus_pins_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
`default_nettype wire

// >>> verification/ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
    input wire logic link_clk_i,
    input wire logic stall_i,
    input wire logic ale_i,
    input wire logic fetch_n_i,
    input wire logic read_n_i,
    input wire logic write_n_i,
    input wire logic [7:0] p0_i,
    input wire logic [7:0] p2_i,
    output logic [7:0] p0_o,
    output logic [7:0] p2_o,
    output logic wait_o = 1'b0
);
// ----------------------------------------
// latch, memory and wait logic
// ----------------------------------------
logic [15:0] lat_q, wdat_q, last_q = 16'h0000;
always @* if (ale_i) lat_q = {p2_i, p0_i};
// data stands through the cycle after the strobe, so take it at its end
always @(posedge write_n_i) wdat_q <= {p2_i, p0_i};
always @(posedge fetch_n_i or posedge read_n_i) last_q <= lat_q ^ 16'h5A_C3;
// released bus shows the inverse, so a stale value never passes
assign {p2_o, p0_o} = (!fetch_n_i || !read_n_i) ? lat_q ^ 16'h5A_C3 : ~last_q;
always @(posedge link_clk_i) wait_o <= stall_i;
endmodule : ext_mem_model
`default_nettype wire

// >>> verification/test_ext_bus_pins.sv
`timescale 1ns/1ps
`default_nettype none
module test_ext_bus_pins;
import ext_bus_pkg::*;
logic CORE_CLK_I = 1'b0, LINK_CLK_I = 1'b0, RESET_I = 1'b1, RESET_PIN_N_I = 1'b1, WDT_RESET_I = 1'b0;
logic CMD_RESET_I = 1'b0, BUS_WIDTH_SELECT_I = 1'b1, BUFFERED_CLOCK_OUTPUT_DISABLE_I = 1'b0, REQ_VALID_I = 1'b0;
logic REQ_HIGH_BYTE_I = 1'b0, strap_on = 1'b1, cs_strap = 1'b1, stall = 1'b0, mwait, wrh_seen;
logic [1:0] P2_ADDR_GROUPS_I = 2'h2, REQ_KIND_I = 2'h0, P4_ADDR_O, P6_ADDR_O;
logic [23:0] REQ_ADDR_I = 24'h00_0000;
logic [15:0] REQ_WDATA_I = 16'h0000, PORT_CFG_I = 16'h0000, RSP_RDATA_O, PORT_CFG_O, rd;
logic [7:0] P0_I, P0_O, P0_OE_O, P2_I, P2_O, P2_OE_O;
logic [3:0] P1_ADDR_O;
logic REQ_READY_O, RSP_VALID_O, CODE_EXTERNAL_O, BUS_WIDE_O, CORE_RESET_O, ADDR_LATCH_O;
logic PROGRAM_FETCH_STROBE_N_O, DATA_READ_STROBE_N_O, LOW_BYTE_WRITE_STROBE_N_O;
logic BUFFERED_CLOCK_OUTPUT_O, RESET_INDICATOR_OUTPUT_N_O;
wire CODE_SOURCE_SELECT_I = strap_on ? cs_strap : mwait;
int error_cnt = 0, n_compared = 0, lat, lat0;
always #5 CORE_CLK_I = ~CORE_CLK_I;
always #32 LINK_CLK_I = ~LINK_CLK_I;
ext_bus_pins u_dut (.*);
ext_mem_model u_mem (.link_clk_i(LINK_CLK_I), .stall_i(stall), .ale_i(ADDR_LATCH_O),
    .fetch_n_i(PROGRAM_FETCH_STROBE_N_O), .read_n_i(DATA_READ_STROBE_N_O),
    .write_n_i(LOW_BYTE_WRITE_STROBE_N_O), .p0_i(P0_O), .p2_i(P2_O), .p0_o(P0_I), .p2_o(P2_I), .wait_o(mwait));
// ----------------------------------------
// tasks
// ----------------------------------------
task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
        error_cnt++;
        $display("MISMATCH %0t seen=%h exp=%h", $time, seen, exp);
    end
endtask : check
function automatic logic [15:0] rdx(input logic [23:0] a);
    return a[19:4] ^ 16'h5A_C3;
endfunction : rdx
// entered at a falling edge; leaves at the one showing the response
task automatic xfer(input logic [1:0] k, input logic [23:0] a, input logic [15:0] d);
    logic [7:0] m;
    m = BUS_WIDTH_SELECT_I ? 8'hFF : {{4{P2_ADDR_GROUPS_I > 2'h1}}, {4{P2_ADDR_GROUPS_I > 2'h0}}};
    {REQ_KIND_I, REQ_ADDR_I, REQ_WDATA_I, REQ_VALID_I} = {k, a, d, 1'b1};
    REQ_HIGH_BYTE_I = (k == KIND_WRITE);
    lat = 0;
    wrh_seen = 1'b0;
    while (!REQ_READY_O && lat < 50) begin
        @(negedge CORE_CLK_I);
        lat++;
    end
    @(negedge CORE_CLK_I);
    REQ_VALID_I = 1'b0;
    lat = 0;
    while (!RSP_VALID_O && lat < 400) begin
        if (ADDR_LATCH_O) begin
            check(P0_O, a[11:4]);
            check({P6_ADDR_O, P4_ADDR_O, P1_ADDR_O[3:1]}, {a[23:20], a[3:1]});
            check({P2_OE_O, P2_O & m}, {m, a[19:12] & m});
            if (!BUS_WIDTH_SELECT_I) check(P1_ADDR_O[0], a[0]);
        end
        wrh_seen |= BUS_WIDTH_SELECT_I && !P1_ADDR_O[0];
        @(negedge CORE_CLK_I);
        lat++;
    end
    rd = RSP_RDATA_O;
endtask : xfer
task automatic settle;
    repeat (5) @(negedge CORE_CLK_I);
    strap_on = 1'b0;
    for (int i = 0; i < 40 && CORE_RESET_O !== 1'b0; i++) @(negedge CORE_CLK_I);
    check(CORE_RESET_O, 1'b0);
endtask : settle
task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
        $display("TEST PASSED");
    else
        $display("TEST FAILED");
    $finish;
endtask : give_verdict
// ----------------------------------------
// sequence
// ----------------------------------------
initial begin
    repeat (12) @(negedge CORE_CLK_I);
    check({P2_O, P0_O, P0_OE_O}, 24'hFF_FF00);
    RESET_I = 1'b0;
    settle();
    check({CODE_EXTERNAL_O, BUS_WIDE_O}, 2'b01);
    xfer(KIND_WRITE, 24'hC3_5A96, 16'hBEEF);
    check({u_mem.wdat_q, wrh_seen}, {16'hBEEF, 1'b1});
    xfer(KIND_READ, 24'h5A_A5F0, 16'h0000);
    check({rd, wrh_seen}, {rdx(24'h5A_A5F0), 1'b0});
    xfer(KIND_FETCH, 24'hFF_FFF8, 16'h0000);
    check(rd, rdx(24'hFF_FFF8));
    lat0 = lat;
    // wait crosses four flops, so raise it well before the strobe
    stall = 1'b1;
    repeat (20) @(negedge CORE_CLK_I);
    fork
        xfer(KIND_READ, 24'h3C_0FF0, 16'h0000);
        begin
            repeat (40) @(negedge CORE_CLK_I);
            stall = 1'b0;
        end
    join
    check({rd, 1'(lat > lat0 + 30)}, {rdx(24'h3C_0FF0), 1'b1});
    BUFFERED_CLOCK_OUTPUT_DISABLE_I = 1'b1;
    repeat (6) @(negedge CORE_CLK_I);
    BUFFERED_CLOCK_OUTPUT_DISABLE_I = 1'b0;
    PORT_CFG_I = 16'hA5_5A;
    repeat (3) @(negedge CORE_CLK_I);
    check(PORT_CFG_O, 16'hA5_5A);
    for (int s = 0; s < 3; s++) begin
        {CMD_RESET_I, WDT_RESET_I, RESET_PIN_N_I} = {s == 2, s == 1, s != 0};
        {cs_strap, BUS_WIDTH_SELECT_I, strap_on} = 3'b001;
        repeat (12) @(negedge CORE_CLK_I);
        check({RESET_INDICATOR_OUTPUT_N_O, CORE_RESET_O}, 2'b01);
        {CMD_RESET_I, WDT_RESET_I, RESET_PIN_N_I} = 3'b001;
        settle();
    end
    check({CODE_EXTERNAL_O, BUS_WIDE_O}, 2'b10);
    for (int g = 0; g < 3; g++) begin
        P2_ADDR_GROUPS_I = g[1:0];
        xfer(KIND_READ, 24'h96_3C5A + g, 16'h0000);
        check(rd[7:0] ^ 8'hC3, 8'hC5);
    end
    xfer(KIND_WRITE, 24'h00_0011, 16'h0077);
    check(u_mem.wdat_q[7:0], 8'h77);
    give_verdict();
end
// span reckoned at about a hundred times the expected run
initial begin
    repeat (20000) @(posedge CORE_CLK_I);
    error_cnt++;
    give_verdict();
end
endmodule : test_ext_bus_pins
`default_nettype wire
